// *** hw/rcf_pkg.sv ***
// reset-cause flag package: register map, flag positions, event carriers
// assumes a 16-bit register port and a core that reports events on the system clock
package rcf_pkg;

  // register indices on the plain register port
  localparam logic [3:0] RCF_REG_STATUS = 4'h0;
  localparam logic [3:0] RCF_REG_IRQ_STAT = 4'h1;
  localparam logic [3:0] RCF_REG_IRQ_MASK = 4'h2;
  localparam logic [3:0] RCF_REG_SEG_LO = 4'h3;
  localparam logic [3:0] RCF_REG_SEG_HI = 4'h4;
  localparam logic [3:0] RCF_REG_WINIT = 4'h5;

  // reset-cause status bit positions
  localparam int RCF_B_TRAP = 15;
  localparam int RCF_B_ILLEGAL = 14;
  localparam int RCF_B_MISMATCH = 9;
  localparam int RCF_B_PIN = 7;
  localparam int RCF_B_SOFT = 6;
  localparam int RCF_B_WDT = 4;
  localparam int RCF_B_SLEEP = 3;
  localparam int RCF_B_IDLE = 2;
  localparam int RCF_B_BOR = 1;
  localparam int RCF_B_POR = 0;

  localparam logic [15:0] RCF_STATUS_MASK = 16'hC2DF;
  localparam logic [15:0] RCF_STATUS_RST = 16'h0001;
  // brown-out keeps the pin-reset flag and the power-on flag
  localparam logic [15:0] RCF_BOR_KEEP = 16'h0081;

  // interrupt status bit positions
  localparam int RCF_IRQ_UNINIT = 0;
  localparam int RCF_IRQ_SECURE = 1;
  localparam int RCF_IRQ_OTHER = 2;
  localparam int RCF_IRQ_W = 3;
  localparam logic [RCF_IRQ_W-1:0] RCF_IRQ_RST = 3'h0;

  // restricted window reset values leave the window empty
  localparam logic [15:0] RCF_SEG_LO_RST = 16'hFFFF;
  localparam logic [15:0] RCF_SEG_HI_RST = 16'h0000;

  localparam int RCF_NWREG = 16;
  localparam int RCF_NTRACK = 15;
  localparam logic [RCF_NTRACK-1:0] RCF_WINIT_RST = 15'h0000;
  localparam logic [3:0] RCF_SP_IDX = 4'hF;

  typedef struct packed {
    logic illegal_opcode;
    logic sw_reset;
    logic wdt_timeout;
    logic trap_conflict;
    logic cfg_mismatch;
    logic power_save_instr_sleep;
    logic power_save_instr_idle;
    logic wdt_clear;
    logic wreg_wr;
    logic [3:0] wreg_wr_idx;
    logic addr_use;
    logic [3:0] addr_use_idx;
    logic program_flow_change;
    logic vector_flow_change;
    logic [23:0] flow_target;
  } rcf_core_evt_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rcf_reg_req_t;

endpackage

// *** hw/rcf_reset_cause.sv ***
// reset-cause detection and reset-cause status flags
// assumes core events arrive on clk; brown-out and reset pin are asynchronous
`timescale 1ns/10ps
module rcf_reset_cause
  import rcf_pkg::*;
(
  input wire logic clk, // 40 MHz system clock
  input wire logic rst, // power-on reset, synchronous
  input wire rcf_core_evt_t core_evt, // core events, one-cycle pulses
  input wire logic brownout_in, // async brown-out detector, high active
  input wire logic ext_reset_pin_n, // async external reset pin, low active
  input wire rcf_reg_req_t reg_req, // register port request
  output logic [15:0] rd_data_q, // read data, cycle after the read strobe
  output logic sys_reset_q, // device reset request pulse
  output logic wreg_clear_q, // working-register clear pulse to the core
  output logic irq_q // level interrupt
);

  // in restricted window: lo <= target page <= hi, used for both flow kinds
  function automatic logic in_window(input logic [23:0] tgt, input logic [15:0] lo,
                                     input logic [15:0] hi);
    in_window = (tgt[23:8] >= lo) && (tgt[23:8] <= hi);
  endfunction

  // synchronisers for the asynchronous inputs
  logic bo_s1_q, bo_s2_q, bo_s3_q;
  logic pin_s1_q, pin_s2_q, pin_s3_q;
  logic bo_s1_d, bo_s2_d, bo_s3_d;
  logic pin_s1_d, pin_s2_d, pin_s3_d;

  always_comb
  begin
    bo_s1_d = brownout_in;
    bo_s2_d = bo_s1_q;
    bo_s3_d = bo_s2_q;
    pin_s1_d = ext_reset_pin_n;
    pin_s2_d = pin_s1_q;
    pin_s3_d = pin_s2_q;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bo_s1_q <= 1'b0;
      bo_s2_q <= 1'b0;
      bo_s3_q <= 1'b0;
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end
    else
    begin
      bo_s1_q <= bo_s1_d;
      bo_s2_q <= bo_s2_d;
      bo_s3_q <= bo_s3_d;
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
      pin_s3_q <= pin_s3_d;
    end
  end

  // assertion edges only; a held level raises one event
  logic bor_evt;
  logic pin_evt;
  assign bor_evt = bo_s2_q && !bo_s3_q;
  assign pin_evt = !pin_s2_q && pin_s3_q;

  // working-register initialisation tracking
  logic [RCF_NTRACK-1:0] winit_q, winit_d;
  logic uninit_evt;
  logic secure_evt;
  logic any_reset;
  logic [15:0] seg_lo_q, seg_hi_q;

  assign uninit_evt = core_evt.addr_use && (core_evt.addr_use_idx != RCF_SP_IDX) &&
                      !winit_q[core_evt.addr_use_idx];

  assign secure_evt = (core_evt.program_flow_change || core_evt.vector_flow_change) &&
                      in_window(core_evt.flow_target, seg_lo_q, seg_hi_q);

  assign any_reset = uninit_evt || secure_evt || core_evt.illegal_opcode ||
                     core_evt.sw_reset || core_evt.wdt_timeout || core_evt.trap_conflict ||
                     core_evt.cfg_mismatch || bor_evt || pin_evt;

  genvar gi;
  generate
    for (gi = 0; gi < RCF_NTRACK; gi++)
    begin : g_winit
      always_comb
      begin
        winit_d[gi] = winit_q[gi];
        if (core_evt.wreg_wr && (core_evt.wreg_wr_idx == 4'(gi)))
          winit_d[gi] = 1'b1;
        if (any_reset)
          winit_d[gi] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (rst)
      winit_q <= RCF_WINIT_RST;
    else
      winit_q <= winit_d;
  end

  // reset-cause status register
  logic [15:0] status_q, status_d;
  logic [15:0] set_v;
  logic wr_status;

  assign wr_status = reg_req.wr && (reg_req.addr == RCF_REG_STATUS);

  always_comb
  begin
    set_v = 16'h0000;
    set_v[RCF_B_TRAP] = core_evt.trap_conflict;
    set_v[RCF_B_ILLEGAL] = core_evt.illegal_opcode || uninit_evt || secure_evt;
    set_v[RCF_B_MISMATCH] = core_evt.cfg_mismatch;
    set_v[RCF_B_PIN] = pin_evt;
    set_v[RCF_B_SOFT] = core_evt.sw_reset;
    set_v[RCF_B_WDT] = core_evt.wdt_timeout;
    set_v[RCF_B_SLEEP] = core_evt.power_save_instr_sleep;
    set_v[RCF_B_IDLE] = core_evt.power_save_instr_idle;
    set_v[RCF_B_BOR] = bor_evt;
  end

  always_comb
  begin
    status_d = status_q;
    if (wr_status)
      status_d = reg_req.wdata & RCF_STATUS_MASK;
    if (core_evt.power_save_instr_sleep || core_evt.power_save_instr_idle || core_evt.wdt_clear)
      status_d[RCF_B_WDT] = 1'b0;
    if (bor_evt)
      status_d = status_d & RCF_BOR_KEEP;
    // hardware set wins over any clear in the same cycle
    status_d = status_d | set_v;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      status_q <= RCF_STATUS_RST;
    else
      status_q <= status_d;
  end

  // restricted window bounds, software programmable
  logic [15:0] seg_lo_d, seg_hi_d;

  always_comb
  begin
    seg_lo_d = seg_lo_q;
    seg_hi_d = seg_hi_q;
    if (reg_req.wr && (reg_req.addr == RCF_REG_SEG_LO))
      seg_lo_d = reg_req.wdata;
    if (reg_req.wr && (reg_req.addr == RCF_REG_SEG_HI))
      seg_hi_d = reg_req.wdata;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      seg_lo_q <= RCF_SEG_LO_RST;
      seg_hi_q <= RCF_SEG_HI_RST;
    end
    else
    begin
      seg_lo_q <= seg_lo_d;
      seg_hi_q <= seg_hi_d;
    end
  end

  // interrupt status and mask
  logic [RCF_IRQ_W-1:0] irq_stat_q, irq_stat_d;
  logic [RCF_IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic [RCF_IRQ_W-1:0] irq_set;
  logic other_reset;

  assign other_reset = any_reset && !uninit_evt && !secure_evt;

  always_comb
  begin
    irq_set = '0;
    irq_set[RCF_IRQ_UNINIT] = uninit_evt;
    irq_set[RCF_IRQ_SECURE] = secure_evt;
    irq_set[RCF_IRQ_OTHER] = other_reset;
    irq_stat_d = irq_stat_q;
    irq_mask_d = irq_mask_q;
    if (reg_req.wr && (reg_req.addr == RCF_REG_IRQ_STAT))
      irq_stat_d = irq_stat_q & ~reg_req.wdata[RCF_IRQ_W-1:0];
    if (reg_req.wr && (reg_req.addr == RCF_REG_IRQ_MASK))
      irq_mask_d = reg_req.wdata[RCF_IRQ_W-1:0];
    // set wins over write-one-to-clear
    irq_stat_d = irq_stat_d | irq_set;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_stat_q <= RCF_IRQ_RST;
      irq_mask_q <= RCF_IRQ_RST;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
    end
  end

  // outputs: reset pulse, register clear pulse, interrupt level
  logic sys_reset_d, wreg_clear_d, irq_d;

  always_comb
  begin
    sys_reset_d = any_reset;
    wreg_clear_d = any_reset;
    // interrupt follows the registered state, one cycle behind it
    irq_d = |(irq_stat_q & irq_mask_q);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sys_reset_q <= 1'b0;
      wreg_clear_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      sys_reset_q <= sys_reset_d;
      wreg_clear_q <= wreg_clear_d;
      irq_q <= irq_d;
    end
  end

  // read port: data valid only in the cycle after the strobe
  logic [15:0] rd_data_d;

  always_comb
  begin
    rd_data_d = 16'h0000;
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        RCF_REG_STATUS: rd_data_d = status_q;
        RCF_REG_IRQ_STAT: rd_data_d = {13'h0000, irq_stat_q};
        RCF_REG_IRQ_MASK: rd_data_d = {13'h0000, irq_mask_q};
        RCF_REG_SEG_LO: rd_data_d = seg_lo_q;
        RCF_REG_SEG_HI: rd_data_d = seg_hi_q;
        // stack pointer reads as always initialised
        RCF_REG_WINIT: rd_data_d = {1'b1, winit_q};
        default: rd_data_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rd_data_q <= 16'h0000;
    else
      rd_data_q <= rd_data_d;
  end

endmodule

// *** verification/rcf_core_model.sv ***
// core model: emits one-cycle event pulses on the system clock
// assumes the caller starts each event just after a rising edge
`timescale 1ns/10ps
module rcf_core_model
  import rcf_pkg::*;
(
  input wire logic clk, // system clock
  output rcf_core_evt_t evt // event pulses to the block
);
  initial evt = '0;
  task automatic fire(input rcf_core_evt_t e);
    evt <= e;
    @(posedge clk);
    evt <= '0;
  endtask
endmodule

// *** verification/rcf_reset_cause_monitor.sv ***
// checker on the reset-cause block ports
// assumes one clock domain and synchronous rst
`timescale 1ns/10ps
module rcf_reset_cause_monitor
  import rcf_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire rcf_core_evt_t core_evt, // core events
  input wire logic brownout_in, // brown-out input
  input wire logic ext_reset_pin_n, // reset pin
  input wire rcf_reg_req_t reg_req, // register request
  input wire logic [15:0] rd_data_q, // read data
  input wire logic sys_reset_q, // reset pulse
  input wire logic wreg_clear_q, // clear pulse
  input wire logic irq_q // interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_pin_drop;
    $fell(ext_reset_pin_n);
  endsequence
  // shadow of written pointer registers, rebuilt from the core's own writes
  logic [15:0] wr_seen_q, wr_seen_d, wr_live;
  always_comb
  begin
    // a reset pulse means the block has just wiped every register mark
    wr_live = sys_reset_q ? 16'h0000 : wr_seen_q;
    wr_seen_d = wr_live;
    if (core_evt.wreg_wr)
      wr_seen_d[core_evt.wreg_wr_idx] = 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      wr_seen_q <= 16'h0000;
    else
      wr_seen_q <= wr_seen_d;
  end
  a_after_por: assert property ($fell(rst) |-> !sys_reset_q && !irq_q && rd_data_q == 16'h0000)
    else $error("outputs not idle after reset");
  a_uninit_ptr: assert property (core_evt.addr_use && !wr_live[core_evt.addr_use_idx]
    && core_evt.addr_use_idx != 4'hF |=> sys_reset_q)
    else $error("uninitialized pointer without reset");
  a_clear_pair: assert property (wreg_clear_q == sys_reset_q)
    else $error("register clear not paired with reset");
  a_trap_reset: assert property (core_evt.trap_conflict |=> sys_reset_q)
    else $error("trap conflict without reset");
  a_illegal_reset: assert property (core_evt.illegal_opcode |=> sys_reset_q)
    else $error("illegal opcode without reset");
  a_soft_reset: assert property (core_evt.sw_reset |=> sys_reset_q)
    else $error("software reset without reset");
  a_wdt_reset: assert property (core_evt.wdt_timeout |=> sys_reset_q)
    else $error("watchdog without reset");
  a_pin_reset: assert property (s_pin_drop |-> ##[1:4] sys_reset_q)
    else $error("pin drop without reset");
  a_bo_reset: assert property ($rose(brownout_in) |-> ##[1:4] sys_reset_q)
    else $error("brown-out without reset");
  a_rd_idle: assert property (!reg_req.rd |=> rd_data_q == 16'h0000)
    else $error("read data outside read slot");
endmodule
bind rcf_reset_cause rcf_reset_cause_monitor mon_u (.clk(clk), .rst(rst),
  .core_evt(core_evt), .brownout_in(brownout_in), .ext_reset_pin_n(ext_reset_pin_n),
  .reg_req(reg_req), .rd_data_q(rd_data_q), .sys_reset_q(sys_reset_q),
  .wreg_clear_q(wreg_clear_q), .irq_q(irq_q));

// *** verification/tb.sv ***
// self-checking bench for the reset-cause block
// assumes the core model drives events and the bench acts as software
`timescale 1ns/10ps
module tb;
  import rcf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bo = 1'b0;
  logic pin_n = 1'b1;
  rcf_reg_req_t req = '0;
  rcf_core_evt_t evt;
  logic [15:0] rdat;
  logic srst, wclr, irq;
  int errors = 0;
  int check_count = 0;
  always #12.5 clk = ~clk;
  rcf_core_model core_u (.clk(clk), .evt(evt));
  rcf_reset_cause dut_u (.clk(clk), .rst(rst), .core_evt(evt), .brownout_in(bo),
    .ext_reset_pin_n(pin_n), .reg_req(req), .rd_data_q(rdat), .sys_reset_q(srst),
    .wreg_clear_q(wclr), .irq_q(irq));
  task automatic end_sim();
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
    // one idle edge so the next strobe is not assigned in this time step
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    chk("rd_data", e, rdat);
    @(posedge clk);
  endtask
  function automatic rcf_core_evt_t mk(input int f, input logic [3:0] i,
    input logic [23:0] t);
    rcf_core_evt_t e;
    e = '0;
    e.wreg_wr_idx = i;
    e.addr_use_idx = i;
    e.flow_target = t;
    case (f)
      0: e.illegal_opcode = 1'b1;
      1: e.sw_reset = 1'b1;
      2: e.wdt_timeout = 1'b1;
      3: e.trap_conflict = 1'b1;
      4: e.cfg_mismatch = 1'b1;
      5: e.power_save_instr_sleep = 1'b1;
      6: e.power_save_instr_idle = 1'b1;
      7: e.wdt_clear = 1'b1;
      8: e.wreg_wr = 1'b1;
      9: e.addr_use = 1'b1;
      10: e.program_flow_change = 1'b1;
      default: e.vector_flow_change = 1'b1;
    endcase
    return e;
  endfunction
  task automatic ev(input int f, input logic [3:0] i, input logic [23:0] t, input logic r);
    core_u.fire(mk(f, i, t));
    @(negedge clk);
    chk("sys_reset", {15'h0000, r}, {15'h0000, srst});
    chk("wreg_clear", {15'h0000, r}, {15'h0000, wclr});
    @(posedge clk);
  endtask
  task automatic wt();
    int n;
    for (n = 0; n < 8 && srst !== 1'b1; n++)
      @(negedge clk);
    chk("async_reset", 16'h0001, {15'h0000, srst});
    if (srst !== 1'b1)
      end_sim();
    @(posedge clk);
  endtask
  task automatic t_map();
    rd(RCF_REG_STATUS, 16'h0001);
    rd(RCF_REG_SEG_LO, 16'hFFFF);
    rd(RCF_REG_WINIT, 16'h8000);
    wr(4'h6, 16'h1234);
    rd(4'h6, 16'h0000);
    wr(RCF_REG_STATUS, 16'hFFFF);
    rd(RCF_REG_STATUS, 16'hC2DF);
  endtask
  task automatic t_uninit();
    ev(8, 4'h3, 24'h0, 1'b0);
    rd(RCF_REG_WINIT, 16'h8008);
    ev(9, 4'h3, 24'h0, 1'b0);
    ev(9, 4'h4, 24'h0, 1'b1);
    ev(9, 4'h3, 24'h0, 1'b1);
    ev(9, 4'hF, 24'h0, 1'b0);
    rd(RCF_REG_WINIT, 16'h8000);
  endtask
  task automatic t_secure();
    wr(RCF_REG_STATUS, 16'h0000);
    wr(RCF_REG_SEG_LO, 16'h0010);
    wr(RCF_REG_SEG_HI, 16'h0020);
    ev(10, 4'h0, 24'h001000, 1'b1);
    ev(10, 4'h0, 24'h002100, 1'b0);
    ev(11, 4'h0, 24'h0020FF, 1'b1);
    ev(11, 4'h0, 24'h000FFF, 1'b0);
    rd(RCF_REG_STATUS, 16'h4000);
  endtask
  task automatic t_flags();
    int fs[7] = '{3, 0, 4, 1, 2, 5, 6};
    int bs[7] = '{15, 14, 9, 6, 4, 3, 2};
    for (int k = 0; k < 7; k++)
    begin
      wr(RCF_REG_STATUS, 16'h0000);
      ev(fs[k], 4'h0, 24'h0, fs[k] < 5);
      rd(RCF_REG_STATUS, 16'h0001 << bs[k]);
    end
    ev(2, 4'h0, 24'h0, 1'b1);
    ev(7, 4'h0, 24'h0, 1'b0);
    rd(RCF_REG_STATUS, 16'h0004);
  endtask
  task automatic t_irq();
    // earlier scenarios left all three causes pending
    wr(RCF_REG_IRQ_STAT, 16'h0007);
    wr(RCF_REG_IRQ_MASK, 16'h0001);
    @(negedge clk);
    chk("irq_idle", 16'h0000, {15'h0000, irq});
    @(posedge clk);
    ev(9, 4'h6, 24'h0, 1'b1);
    @(negedge clk);
    chk("irq", 16'h0001, {15'h0000, irq});
    @(posedge clk);
    rd(RCF_REG_IRQ_STAT, 16'h0001);
    wr(RCF_REG_IRQ_STAT, 16'h0001);
    wr(RCF_REG_IRQ_MASK, 16'h0000);
    ev(1, 4'h0, 24'h0, 1'b1);
    rd(RCF_REG_IRQ_STAT, 16'h0004);
    @(negedge clk);
    chk("irq_masked", 16'h0000, {15'h0000, irq});
    @(posedge clk);
  endtask
  task automatic t_power();
    wr(RCF_REG_STATUS, 16'h0000);
    pin_n <= 1'b0;
    wt();
    pin_n <= 1'b1;
    rd(RCF_REG_STATUS, 16'h0080);
    // keep the pin flag so brown-out can be seen to spare it
    wr(RCF_REG_STATUS, 16'hC2DC);
    bo <= 1'b1;
    wt();
    bo <= 1'b0;
    rd(RCF_REG_STATUS, 16'h0082);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(RCF_REG_STATUS, 16'h0001);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_map();
    t_uninit();
    t_secure();
    t_flags();
    t_irq();
    t_power();
    end_sim();
  end
endmodule
